// [pwas_port.sv]
`include "pwas_defines.svh"

module pwas_port (
  input wire logic mclk,
  input wire logic rst_n,
  // register access: port address register and port control register
  input wire pwas_pkg::pwas_req_t req,
  output logic [`PWAS_W-1:0] rdata,
  output logic ctl_hit,
  // from the rest of the port, same clock domain
  input wire logic [`PWAS_W-1:0] altfunc_enable_reg,
  input wire logic stop_mode,
  // raw pad levels, asynchronous
  input wire logic [`PWAS_W-1:0] pin_in,
  // pin controls
  output logic [`PWAS_W-1:0] pullup_on,
  output logic [`PWAS_W-1:0] gpio_mode,
  output logic [`PWAS_AF_FUNCS*`PWAS_W-1:0] altfunc_sel,
  output logic [`PWAS_W-1:0] wake_source_enable_bit,
  output logic wake_req
);

  // ------------------------------------------------------------------
  // helpers
  // ------------------------------------------------------------------

  // true when the held index names the given subregister
  function automatic logic idx_is(input logic [`PWAS_IDX_W-1:0] idx,
                                  input logic [`PWAS_IDX_W-1:0] code);
    idx_is = (idx == code);
  endfunction

  // true when the index belongs to any subregister kept here
  function automatic logic idx_ours(input logic [`PWAS_IDX_W-1:0] idx);
    idx_ours = idx_is(idx, `PWAS_IDX_WAKE) | idx_is(idx, `PWAS_IDX_PULL) |
               idx_is(idx, `PWAS_IDX_AFS1) | idx_is(idx, `PWAS_IDX_AFS2);
  endfunction

  // ------------------------------------------------------------------
  // port address register
  // ------------------------------------------------------------------

  // index written by software; steers every control register access
  logic [`PWAS_IDX_W-1:0] idx_ff;
  logic [`PWAS_IDX_W-1:0] nxt_idx;

  // strobes split by target register
  wire addr_wr = req.wr & (req.sel == `PWAS_SEL_ADDR);
  wire addr_rd = req.rd & (req.sel == `PWAS_SEL_ADDR);
  wire ctl_wr = req.wr & (req.sel == `PWAS_SEL_CTL);
  wire ctl_rd = req.rd & (req.sel == `PWAS_SEL_CTL);

  // the index register takes any value; foreign indices belong to
  // other subregisters of the port and are simply not decoded here
  assign nxt_idx = addr_wr ? req.wdata : idx_ff;

  // index register
  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      idx_ff <= `PWAS_RST_IDX;
    end else begin
      idx_ff <= nxt_idx;
    end
  end

  // ------------------------------------------------------------------
  // subregister decode
  // ------------------------------------------------------------------

  // per-subregister selects from the held index
  wire sel_wake = idx_is(idx_ff, `PWAS_IDX_WAKE);
  wire sel_pull = idx_is(idx_ff, `PWAS_IDX_PULL);
  wire sel_afs1 = idx_is(idx_ff, `PWAS_IDX_AFS1);
  wire sel_afs2 = idx_is(idx_ff, `PWAS_IDX_AFS2);

  // the control register is answered here only for our four indices;
  // the rest of the port muxes its own subregisters on a miss
  assign ctl_hit = idx_ours(idx_ff);

  // ------------------------------------------------------------------
  // the four subregisters
  // ------------------------------------------------------------------

  pwas_pkg::pwas_cfg_t cfg_ff;   // stored configuration
  pwas_pkg::pwas_cfg_t nxt_cfg;  // next configuration

  // a write through the control register lands only in the selected one
  assign nxt_cfg.wake_source_enable_reg = (ctl_wr & sel_wake) ? req.wdata :
                                          cfg_ff.wake_source_enable_reg;
  assign nxt_cfg.pullup_enable_reg = (ctl_wr & sel_pull) ? req.wdata :
                                     cfg_ff.pullup_enable_reg;
  assign nxt_cfg.altfunc_set_one_reg = (ctl_wr & sel_afs1) ? req.wdata :
                                       cfg_ff.altfunc_set_one_reg;
  assign nxt_cfg.altfunc_set_two_reg = (ctl_wr & sel_afs2) ? req.wdata :
                                       cfg_ff.altfunc_set_two_reg;

  // all four clear at reset
  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      cfg_ff.wake_source_enable_reg <= `PWAS_RST_REG;
      cfg_ff.pullup_enable_reg <= `PWAS_RST_REG;
      cfg_ff.altfunc_set_one_reg <= `PWAS_RST_REG;
      cfg_ff.altfunc_set_two_reg <= `PWAS_RST_REG;
    end else begin
      cfg_ff <= nxt_cfg;
    end
  end

  // ------------------------------------------------------------------
  // read path
  // ------------------------------------------------------------------

  // read data is registered so the bus sees it one cycle after the strobe
  logic [`PWAS_W-1:0] rdata_ff;
  logic [`PWAS_W-1:0] nxt_rdata;
  logic [`PWAS_W-1:0] ctl_view;

  // control register view of the selected subregister; misses read zero
  assign ctl_view = sel_wake ? cfg_ff.wake_source_enable_reg :
                    sel_pull ? cfg_ff.pullup_enable_reg :
                    sel_afs1 ? cfg_ff.altfunc_set_one_reg :
                    sel_afs2 ? cfg_ff.altfunc_set_two_reg :
                    `PWAS_RST_RDATA;

  // hold the last answer between reads so the bus never sees a glitch
  assign nxt_rdata = addr_rd ? idx_ff :
                     ctl_rd ? ctl_view :
                     rdata_ff;

  // read data register
  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      rdata_ff <= `PWAS_RST_RDATA;
    end else begin
      rdata_ff <= nxt_rdata;
    end
  end

  assign rdata = rdata_ff;

  // ------------------------------------------------------------------
  // pull-up control and wake enable export
  // ------------------------------------------------------------------

  // the pad cell takes the stored bit straight from its flop
  assign pullup_on = cfg_ff.pullup_enable_reg;

  // the wake enables are exported so the port can gate its pad receivers
  assign wake_source_enable_bit = cfg_ff.wake_source_enable_reg;

  // ------------------------------------------------------------------
  // alternate function selection
  // ------------------------------------------------------------------

  // registered pin controls; the alternate enable arrives from another
  // register of the port, so the mux output lags it by one cycle,
  // traded for clean flop-driven outputs toward the pad ring
  logic [`PWAS_W-1:0] gpio_mode_ff;
  logic [`PWAS_W-1:0] nxt_gpio_mode;
  logic [`PWAS_AF_FUNCS*`PWAS_W-1:0] altfunc_sel_ff;
  logic [`PWAS_AF_FUNCS*`PWAS_W-1:0] nxt_altfunc_sel;

  // a pin without its alternate enable is plain gpio
  assign nxt_gpio_mode = ~altfunc_enable_reg;

  // one-hot function enables: slice k holds pin n of function k
  genvar gp;
  generate
    for (gp = 0; gp < `PWAS_W; gp++) begin : g_pin
      // function number from the two selector bits, second one high
      wire [`PWAS_AF_NUM_W-1:0] fnum = {cfg_ff.altfunc_set_two_reg[gp],
                                       cfg_ff.altfunc_set_one_reg[gp]};
      genvar gf;
      for (gf = 0; gf < `PWAS_AF_FUNCS; gf++) begin : g_func
        // the loop index as a plain integer, so its low bits can be sliced
        localparam int FNUM_INT = gf;
        // selectors count only while the enable bit is set
        assign nxt_altfunc_sel[gf*`PWAS_W+gp] = altfunc_enable_reg[gp] &
               (fnum == FNUM_INT[`PWAS_AF_NUM_W-1:0]);
      end
    end
  endgenerate

  // pin control flops
  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      gpio_mode_ff <= {`PWAS_W{1'b1}};
      altfunc_sel_ff <= '0;
    end else begin
      gpio_mode_ff <= nxt_gpio_mode;
      altfunc_sel_ff <= nxt_altfunc_sel;
    end
  end

  assign gpio_mode = gpio_mode_ff;
  assign altfunc_sel = altfunc_sel_ff;

  // ------------------------------------------------------------------
  // stop-mode wake detection
  // ------------------------------------------------------------------

  // pads are asynchronous: two flops before anything looks at them
  logic [`PWAS_W-1:0] pin_sync;

  pwas_sync #(
    .W(`PWAS_W),
    .STAGES(`PWAS_SYNC_STAGES)
  ) u_sync (
    .mclk(mclk),
    .rst_n(rst_n),
    .d_async(pin_in),
    .q_sync(pin_sync)
  );

  // previous synchronised level for edge detection; it tracks at all
  // times so entering stop never sees a stale edge
  logic [`PWAS_W-1:0] pin_prev_ff;
  // warm-up shift, one stage per synchroniser flop plus the history flop;
  // the chain resets to zero, so a pad already high at release would
  // otherwise show up as a false edge two cycles later
  logic [`PWAS_SYNC_STAGES:0] warm_ff;
  logic [`PWAS_SYNC_STAGES:0] nxt_warm;
  // history is trusted only once the whole chain holds real pad levels
  wire prev_valid = warm_ff[`PWAS_SYNC_STAGES];
  assign nxt_warm = {warm_ff[`PWAS_SYNC_STAGES-1:0], 1'b1};

  // either direction counts, masked by the wake enables
  wire [`PWAS_W-1:0] pin_edge = (pin_sync ^ pin_prev_ff) & {`PWAS_W{prev_valid}};
  wire [`PWAS_W-1:0] wake_hits = pin_edge & cfg_ff.wake_source_enable_reg;
  wire wake_any = |wake_hits;

  // edge history and its warm-up; no edge counts until the synchroniser
  // and the history flop have both been refilled after reset
  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      pin_prev_ff <= '0;
      warm_ff <= '0;
    end else begin
      pin_prev_ff <= pin_sync;
      warm_ff <= nxt_warm;
    end
  end

  // wake tracker: recovery holds until the core leaves stop mode.
  // limitation: the clock must keep running in stop for this to see
  // edges; a gated-clock system needs an asynchronous wake path instead
  pwas_pkg::pwas_wake_state_t state_ff;
  pwas_pkg::pwas_wake_state_t nxt_state;

  // next-state decode
  always_comb begin
    nxt_state = state_ff;
    case (state_ff)
      pwas_pkg::PWAS_RUN: begin
        // an edge in the entry cycle already counts
        if (stop_mode) begin
          nxt_state = wake_any ? pwas_pkg::PWAS_RECOVER : pwas_pkg::PWAS_STOP;
        end
      end
      pwas_pkg::PWAS_STOP: begin
        if (!stop_mode) begin
          // stop left for another reason
          nxt_state = pwas_pkg::PWAS_RUN;
        end else if (wake_any) begin
          nxt_state = pwas_pkg::PWAS_RECOVER;
        end
      end
      pwas_pkg::PWAS_RECOVER: begin
        // hold the request until the core has left stop
        if (!stop_mode) begin
          nxt_state = pwas_pkg::PWAS_RUN;
        end
      end
      default: begin
        nxt_state = pwas_pkg::PWAS_RUN;
      end
    endcase
  end

  // state register
  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      state_ff <= pwas_pkg::PWAS_RUN;
    end else begin
      state_ff <= nxt_state;
    end
  end

  // request is a direct decode of the state flop
  assign wake_req = (state_ff == pwas_pkg::PWAS_RECOVER);

endmodule // pwas_port

// [pwas_defines.svh]
`ifndef PWAS_DEFINES_SVH
`define PWAS_DEFINES_SVH

// width of every port subregister and of the pin group it controls
`define PWAS_W 8
// width of the index held in the port address register
`define PWAS_IDX_W 8

// subregister indices decoded from the port address register
`define PWAS_IDX_WAKE 8'h05
`define PWAS_IDX_PULL 8'h06
`define PWAS_IDX_AFS1 8'h07
`define PWAS_IDX_AFS2 8'h08

// reset values
`define PWAS_RST_REG 8'h00
`define PWAS_RST_IDX 8'h00
`define PWAS_RST_RDATA 8'h00

// register select on the access port
`define PWAS_SEL_ADDR 1'b0
`define PWAS_SEL_CTL 1'b1

// number of alternate functions a pin can pick from
`define PWAS_AF_FUNCS 4
// width of the per-pin function number
`define PWAS_AF_NUM_W 2

// synchroniser depth for pad inputs
`define PWAS_SYNC_STAGES 2

`endif

// [pwas_pkg.sv]
`include "pwas_defines.svh"

package pwas_pkg;

  // one access to the port address or port control register
  typedef struct packed {
    logic sel;                    // address register or control register
    logic wr;                     // write strobe, one cycle
    logic rd;                     // read strobe, one cycle
    logic [`PWAS_W-1:0] wdata;    // write data
  } pwas_req_t;

  // the four subregisters held by this block
  typedef struct packed {
    logic [`PWAS_W-1:0] wake_source_enable_reg;
    logic [`PWAS_W-1:0] pullup_enable_reg;
    logic [`PWAS_W-1:0] altfunc_set_one_reg;
    logic [`PWAS_W-1:0] altfunc_set_two_reg;
  } pwas_cfg_t;

  // wake tracking states
  typedef enum logic [1:0] {
    PWAS_RUN,
    PWAS_STOP,
    PWAS_RECOVER
  } pwas_wake_state_t;

endpackage : pwas_pkg

// [pwas_sync.sv]
`include "pwas_defines.svh"

// plain multi-stage synchroniser for asynchronous pad levels
module pwas_sync #(
  parameter int W = `PWAS_W,
  parameter int STAGES = `PWAS_SYNC_STAGES
) (
  input wire logic mclk,
  input wire logic rst_n,
  input wire logic [W-1:0] d_async,
  output logic [W-1:0] q_sync
);

  // chain of flops; only the last stage is visible outside
  logic [W-1:0] chain_ff [STAGES];

  // shift the pad level through the chain
  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      for (int i = 0; i < STAGES; i++) begin
        chain_ff[i] <= '0;
      end
    end else begin
      chain_ff[0] <= d_async;
      for (int i = 1; i < STAGES; i++) begin
        chain_ff[i] <= chain_ff[i-1];
      end
    end
  end

  assign q_sync = chain_ff[STAGES-1];

endmodule // pwas_sync

// [pwas_port_assertions.sv]
`include "pwas_defines.svh"

// watches the port pins of the wake, pull-up and set selector block
module pwas_port_chk (
  input wire logic mclk,
  input wire logic rst_n,
  input wire pwas_pkg::pwas_req_t req,
  input wire logic [7:0] rdata,
  input wire logic ctl_hit,
  input wire logic [7:0] altfunc_enable_reg,
  input wire logic stop_mode,
  input wire logic [7:0] pin_in,
  input wire logic [7:0] pullup_on,
  input wire logic [7:0] gpio_mode,
  input wire logic [31:0] altfunc_sel,
  input wire logic [7:0] wake_source_enable_bit,
  input wire logic wake_req
);
  // one slice per function number
  wire [7:0] f0 = altfunc_sel[7:0];
  wire [7:0] f1 = altfunc_sel[15:8];
  wire [7:0] f2 = altfunc_sel[23:16];
  wire [7:0] f3 = altfunc_sel[31:24];
  // a pin picking two functions at once would fight on the pad
  wire [7:0] twice = f0 & f1 | f0 & f2 | f0 & f3 | f1 & f2 | f1 & f3 | f2 & f3;
  wire ctl_wr = req.wr && req.sel && ctl_hit;
  default clocking @(posedge mclk); endclocking
  default disable iff (!rst_n);
  a_gpio_lag: assert property (gpio_mode == ~$past(altfunc_enable_reg))
    else $error("gpio mode does not follow enable");
  a_gpio_no_func: assert property (((f0 | f1 | f2 | f3) & gpio_mode) == 8'h00)
    else $error("function picked on gpio pin");
  a_one_of_four: assert property ((f0 | f1 | f2 | f3) == ~gpio_mode && twice == 8'h00)
    else $error("function select not one of four");
  a_pullup_quiet: assert property (!ctl_wr |=> $stable(pullup_on))
    else $error("pull-up changed without write");
  a_miss_zero: assert property (req.rd && req.sel && !ctl_hit |=> rdata == 8'h00)
    else $error("miss read not zero");
  a_wake_hold: assert property (wake_req && stop_mode |=> wake_req)
    else $error("wake request dropped in stop");
  a_wake_off_run: assert property (!stop_mode |=> !wake_req)
    else $error("wake request outside stop");
  a_wake_needs_en: assert property ($rose(wake_req) |->
    ($past(wake_source_enable_bit, 1) | $past(wake_source_enable_bit, 2)) != 8'h00)
    else $error("wake without enabled pin");
  a_wake_prompt: assert property ((|((pin_in ^ $past(pin_in)) & wake_source_enable_bit))
    ##0 stop_mode [*3] |-> ##[0:2] wake_req)
    else $error("enabled edge gave no wake");
  c_wake: cover property ($rose(wake_req));
  c_func: cover property (f3 != 8'h00);
  c_miss: cover property (req.rd && req.sel && !ctl_hit);
endmodule // pwas_port_chk

bind pwas_port pwas_port_chk u_chk (.mclk(mclk), .rst_n(rst_n), .req(req), .rdata(rdata),
  .ctl_hit(ctl_hit), .altfunc_enable_reg(altfunc_enable_reg), .stop_mode(stop_mode),
  .pin_in(pin_in), .pullup_on(pullup_on), .gpio_mode(gpio_mode), .altfunc_sel(altfunc_sel),
  .wake_source_enable_bit(wake_source_enable_bit), .wake_req(wake_req));

// [tb.sv]
`include "pwas_defines.svh"

// random register traffic plus hand-made wake and miss cases
module tb;
  timeunit 1ns;
  timeprecision 1ps;
  logic mclk = 0;
  logic rst_n = 0;
  pwas_pkg::pwas_req_t req = '0;
  logic [7:0] rdata, pullup_on, gpio_mode, wake_source_enable_bit, v, s1, s2;
  logic [7:0] af_en = 0;
  logic [7:0] pin_in = 0;
  logic [31:0] altfunc_sel;
  logic ctl_hit, wake_req;
  logic stop_mode = 0;
  int n_errors = 0;
  int tests_run = 0;

  // 200 MHz
  initial forever #2.5 mclk = ~mclk;

  pwas_port dut (.mclk(mclk), .rst_n(rst_n), .req(req), .rdata(rdata), .ctl_hit(ctl_hit),
    .altfunc_enable_reg(af_en), .stop_mode(stop_mode), .pin_in(pin_in), .pullup_on(pullup_on),
    .gpio_mode(gpio_mode), .altfunc_sel(altfunc_sel),
    .wake_source_enable_bit(wake_source_enable_bit), .wake_req(wake_req));

  task print_verdict();
    $display("errors %0d checks %0d", n_errors, tests_run);
    if (n_errors == 0 && tests_run > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask

  task chk(string nm, logic [31:0] e, logic [31:0] g);
    tests_run++;
    if (g !== e) begin
      n_errors++;
      $display("Error %s exp %h got %h", nm, e, g);
    end
  endtask

  // strobes rise and fall on different falling edges, so no double drive
  task wr(logic s, logic [7:0] d);
    @(negedge mclk);
    req.sel = s;
    req.wr = 1;
    req.wdata = d;
    @(negedge mclk);
    req.wr = 0;
  endtask

  // read data is settled by the falling edge after the taking edge
  task rd(logic s, output logic [7:0] d);
    @(negedge mclk);
    req.sel = s;
    req.rd = 1;
    @(negedge mclk);
    req.rd = 0;
    d = rdata;
  endtask

  // select a subregister and compare its read-back
  task cr(logic [7:0] idx, logic [7:0] e);
    logic [7:0] d;
    wr(0, idx);
    chk("ctl_hit", 1, ctl_hit);
    rd(1, d);
    chk("subreg", e, d);
  endtask

  // one-hot select per pin, function number is {set two, set one}
  function logic [31:0] af_exp(logic [7:0] en, logic [7:0] a, logic [7:0] b);
    af_exp = 0;
    for (int n = 0; n < 8; n++)
      if (en[n])
        af_exp[{b[n], a[n]} * 8 + n] = 1'b1;
  endfunction

  // bounded wait for the wake request
  task wt();
    for (int j = 0; j < 8 && wake_req !== 1'b1; j++)
      @(negedge mclk);
  endtask

  // cuts a hang short
  initial begin
    #100us;
    n_errors++;
    print_verdict();
  end

  initial begin
    void'($urandom(24));
    repeat (8) @(negedge mclk);
    rst_n = 1;
    // every subregister clears at reset
    for (int i = 5; i < 9; i++)
      cr(i[7:0], 8'h00);
    chk("gpio_rst", 8'hff, gpio_mode);
    // random contents, with the enable moving under them
    repeat (20) begin
      s1 = 8'($urandom);
      s2 = 8'($urandom);
      v = 8'($urandom);
      af_en = 8'($urandom);
      wr(0, `PWAS_IDX_AFS1);
      wr(1, s1);
      wr(0, `PWAS_IDX_AFS2);
      wr(1, s2);
      wr(0, `PWAS_IDX_PULL);
      wr(1, v);
      wr(0, `PWAS_IDX_WAKE);
      wr(1, ~v);
      cr(`PWAS_IDX_AFS1, s1);
      cr(`PWAS_IDX_AFS2, s2);
      cr(`PWAS_IDX_PULL, v);
      cr(`PWAS_IDX_WAKE, ~v);
      chk("pullup_on", v, pullup_on);
      chk("wake_en", 8'(~v), wake_source_enable_bit);
      chk("gpio_mode", 8'(~af_en), gpio_mode);
      chk("altfunc_sel", af_exp(af_en, s1, s2), altfunc_sel);
    end
    // indices just outside the window: ignored, read as zero
    for (int i = 0; i < 2; i++) begin
      s1 = i ? 8'h09 : 8'h04;
      wr(0, s1);
      chk("ctl_hit", 0, ctl_hit);
      rd(0, s2);
      chk("index", s1, s2);
      wr(1, 8'hff);
      rd(1, s2);
      chk("miss", 8'h00, s2);
    end
    cr(`PWAS_IDX_PULL, v);
    // only pin 2 may wake; both edge directions
    wr(0, `PWAS_IDX_WAKE);
    wr(1, 8'h04);
    for (int i = 0; i < 2; i++) begin
      stop_mode = 1;
      repeat (3) @(negedge mclk);
      pin_in[3] = ~pin_in[3];
      repeat (8) @(negedge mclk);
      chk("no_wake", 0, wake_req);
      pin_in[2] = ~pin_in[2];
      wt();
      chk("wake", 1, wake_req);
      stop_mode = 0;
      repeat (2) @(negedge mclk);
      chk("wake_off", 0, wake_req);
    end
    print_verdict();
  end
endmodule // tb
